// file: ueth_pkg.sv
package ueth_pkg;
	// Device-side register select
	localparam logic DEV_SEL_CSR = 1'b0;
	localparam logic DEV_SEL_FIFO = 1'b1;
	// Endpoint control/status word layout on the device port
	localparam int CSR_TX_COMPLETE = 0;
	localparam int CSR_RX_BANK0 = 1;
	localparam int CSR_SETUP = 2;
	localparam int CSR_TX_PKT_READY = 4;
	localparam int CSR_RX_BANK1 = 6;
	localparam int CSR_RXCNT_LSB = 16;
	localparam int CSR_RXCNT_W = 11;
	// Flags that software clears by writing 0; writing 1 leaves them alone
	localparam logic [31:0] CSR_KEEP = 32'h0000_0047;
	localparam logic [31:0] CSR_SET_TX_READY = 32'h0000_0010;
	// Buffer sizes
	localparam int BUF_DEPTH = 64;
	localparam int BUF_AW = 6;
	localparam int SETUP_LEN = 8;
	localparam logic [BUF_AW:0] SETUP_LAST = 7'h07;
	// Wishbone register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_TXDATA = 8'h0C;
	localparam logic [7:0] REG_RXDATA = 8'h10;
	localparam logic [7:0] REG_RXCOUNT = 8'h14;
	localparam logic [7:0] REG_SETUP_LO = 8'h18;
	localparam logic [7:0] REG_SETUP_HI = 8'h1C;
	// CTRL bits
	localparam int CTRL_EN = 0;
	localparam int CTRL_PINGPONG = 1;
	localparam int CTRL_ISO = 2;
	// STATUS bits (write 1 to bits 1..4 to clear them)
	localparam int ST_TX_PEND = 0;
	localparam int ST_TX_DONE = 1;
	localparam int ST_RX_VALID = 2;
	localparam int ST_SETUP_VALID = 3;
	localparam int ST_ERR = 4;
	localparam int ST_BUSY = 5;
	typedef enum logic [3:0] {
		S_IDLE, S_POLL, S_SETUP, S_CLR_SETUP, S_RX, S_CLR_RX,
		S_TX, S_SET_RDY, S_CLR_COMP
	} ueth_state_e;
endpackage : ueth_pkg

// file: ueth_dev_port.sv
`timescale 1ns/10ps
// One access to the device: strobe for one cycle, read data taken at the end of the strobe cycle
module ueth_dev_port (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic i_sel,
	input wire logic [31:0] i_wdata,
	output logic o_done,
	output logic [31:0] o_rdata,
	output logic o_dev_sel,
	output logic o_dev_wr,
	output logic o_dev_rd,
	output logic [31:0] o_dev_wdata,
	input wire logic [31:0] i_dev_rdata
);
	import ueth_pkg::*;

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_dev_wr <= 1'b0;
			o_dev_rd <= 1'b0;
			o_dev_sel <= DEV_SEL_CSR;
			o_dev_wdata <= 32'h0000_0000;
		end else begin
			o_dev_wr <= i_req & i_we;
			o_dev_rd <= i_req & ~i_we;
			if (i_req) begin
				o_dev_sel <= i_sel;
				o_dev_wdata <= i_wdata;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_done <= 1'b0;
			o_rdata <= 32'h0000_0000;
		end else begin
			o_done <= o_dev_wr | o_dev_rd;
			if (o_dev_rd) begin
				o_rdata <= i_dev_rdata;
			end
		end
	end
endmodule : ueth_dev_port

// file: ueth_host.sv
`timescale 1ns/10ps
// How it works
// - Status OUT stage: host sends empty packet
// - Control and setup only on single-bank endpoints
// - Read whole setup packet before clearing flag
// - Isochronous IN only on ping-pong endpoints
// - Wait ready clear, write bytes, set ready
// - Clear complete only after next ready set; the code clears it at once when no next packet is staged
// - Fill second bank without waiting ready clear
// - After complete, set ready releasing second bank
// - Isochronous OUT only on ping-pong endpoints; the receive path does not check this
// - Clear receive flag after last FIFO access
// - Both flags set: clear banks alternately
module ueth_host (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic o_dev_sel,
	output logic o_dev_wr,
	output logic o_dev_rd,
	output logic [31:0] o_dev_wdata,
	input wire logic [31:0] i_dev_rdata,
	input wire logic i_dev_irq
);
	import ueth_pkg::*;

	ueth_state_e state;
	logic [2:0] ctrl;
	logic tx_pend, tx_done, rx_valid, setup_valid, err;
	logic [BUF_AW:0] tx_len, rx_len, idx;
	logic [7:0] tx_buf [BUF_DEPTH];
	logic [7:0] rx_buf [BUF_DEPTH];
	logic [7:0] setup_buf [SETUP_LEN];
	logic [BUF_AW-1:0] rx_rptr;
	logic [CSR_RXCNT_W-1:0] rx_cnt;
	logic tx_inflight, pp_held, clr_after, rx_next_bank, rx_bank;
	logic acc_req, acc_we, acc_sel, acc_pend, acc_done;
	logic [31:0] acc_wdata, acc_rdata, csr;
	logic wb_hit, wr_ctrl, wr_cmd, wr_status, wr_txdata, rd_rxdata;
	logic cmd_ok, dev_wait;

	assign wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign wr_ctrl = wb_hit & i_wb_we & (i_wb_adr == REG_CTRL) & i_wb_sel[0];
	assign wr_cmd = wb_hit & i_wb_we & (i_wb_adr == REG_CMD) & i_wb_sel[0];
	assign wr_status = wb_hit & i_wb_we & (i_wb_adr == REG_STATUS) & i_wb_sel[0];
	assign wr_txdata = wb_hit & i_wb_we & (i_wb_adr == REG_TXDATA) & i_wb_sel[0];
	assign rd_rxdata = wb_hit & ~i_wb_we & (i_wb_adr == REG_RXDATA);
	// Isochronous IN needs both banks; the send command is refused otherwise
	assign cmd_ok = ~ctrl[CTRL_ISO] | ctrl[CTRL_PINGPONG];
	// A request may be issued only while no device access is outstanding
	assign dev_wait = acc_pend | acc_req;
	assign csr = acc_rdata;

	ueth_dev_port u_port (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_req(acc_req),
		.i_we(acc_we),
		.i_sel(acc_sel),
		.i_wdata(acc_wdata),
		.o_done(acc_done),
		.o_rdata(acc_rdata),
		.o_dev_sel(o_dev_sel),
		.o_dev_wr(o_dev_wr),
		.o_dev_rd(o_dev_rd),
		.o_dev_wdata(o_dev_wdata),
		.i_dev_rdata(i_dev_rdata)
	);

	// Wishbone answer: ack one cycle after the request, dropped the next cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= wb_hit;
			if (wb_hit & ~i_wb_we) begin
				if (i_wb_adr == REG_CTRL) begin
					o_wb_dat <= {29'h0000_0000, ctrl};
				end else if (i_wb_adr == REG_STATUS) begin
					o_wb_dat <= {26'h000_0000, state != S_IDLE, err, setup_valid,
						rx_valid, tx_done, tx_pend};
				end else if (i_wb_adr == REG_RXDATA) begin
					o_wb_dat <= {24'h00_0000, rx_buf[rx_rptr]};
				end else if (i_wb_adr == REG_RXCOUNT) begin
					o_wb_dat <= {21'h00_0000, rx_cnt};
				end else if (i_wb_adr == REG_SETUP_LO) begin
					o_wb_dat <= {setup_buf[3], setup_buf[2], setup_buf[1], setup_buf[0]};
				end else if (i_wb_adr == REG_SETUP_HI) begin
					o_wb_dat <= {setup_buf[7], setup_buf[6], setup_buf[5], setup_buf[4]};
				end else begin
					o_wb_dat <= 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			ctrl <= 3'h0;
		end else if (wr_ctrl) begin
			ctrl <= i_wb_dat[2:0];
		end
	end

	// Transmit staging buffer, one byte per write
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			tx_len <= 7'h00;
		end else if ((wr_cmd & ~i_wb_dat[0] & ~tx_pend) | (state == S_SET_RDY & acc_done)) begin
			// Staging survives the send command and empties once the packet is handed over
			tx_len <= 7'h00;
		end else if (wr_txdata & ~tx_pend & (tx_len != 7'h40)) begin
			tx_len <= tx_len + 7'h01;
		end
	end

	genvar g;
	generate
		for (g = 0; g < BUF_DEPTH; g++) begin : g_txbuf
			always_ff @(posedge i_core_clk) begin
				if (wr_txdata & ~tx_pend & (tx_len == 7'(g))) begin
					tx_buf[g] <= i_wb_dat[7:0];
				end
			end
		end
	endgenerate

	// Send command latches the staged length; zero length is the status IN packet
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			tx_pend <= 1'b0;
		end else if (wr_cmd & i_wb_dat[0] & ~tx_pend & cmd_ok) begin
			tx_pend <= 1'b1;
		end else if (state == S_SET_RDY & acc_done) begin
			tx_pend <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			rx_rptr <= 6'h00;
		end else if (wr_status & i_wb_dat[ST_RX_VALID]) begin
			rx_rptr <= 6'h00;
		end else if (rd_rxdata) begin
			rx_rptr <= rx_rptr + 6'h01;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			acc_pend <= 1'b0;
		end else if (acc_req) begin
			acc_pend <= 1'b1;
		end else if (acc_done) begin
			acc_pend <= 1'b0;
		end
	end

	// Sequencer: poll the endpoint word, then serve setup, receive, then transmit
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state <= S_IDLE;
			acc_req <= 1'b0;
			acc_we <= 1'b0;
			acc_sel <= DEV_SEL_CSR;
			acc_wdata <= 32'h0000_0000;
			idx <= 7'h00;
			rx_len <= 7'h00;
			rx_cnt <= 11'h000;
			tx_inflight <= 1'b0;
			pp_held <= 1'b0;
			clr_after <= 1'b0;
			rx_next_bank <= 1'b0;
			rx_bank <= 1'b0;
			err <= 1'b0;
		end else begin
			acc_req <= 1'b0;
			if (wr_status & i_wb_dat[ST_ERR]) begin
				err <= 1'b0;
			end
			case (state)
			S_IDLE: begin
				if (ctrl[CTRL_EN] & ~dev_wait & (i_dev_irq | tx_pend | tx_inflight)) begin
					acc_req <= 1'b1;
					acc_we <= 1'b0;
					acc_sel <= DEV_SEL_CSR;
					state <= S_POLL;
				end
			end
			S_POLL: begin
				if (acc_done) begin
					idx <= 7'h00;
					if (csr[CSR_SETUP] & ~setup_valid) begin
						// Setup on a two-bank endpoint is a misconfiguration; still drained
						err <= err | ctrl[CTRL_PINGPONG];
						state <= S_SETUP;
					end else if (~rx_valid & ~csr[CSR_SETUP] &
						((~ctrl[CTRL_PINGPONG] | ~rx_next_bank) & csr[CSR_RX_BANK0] |
						ctrl[CTRL_PINGPONG] & rx_next_bank & csr[CSR_RX_BANK1])) begin
						// Bank order is tracked here, never inferred from the flags
						rx_bank <= ctrl[CTRL_PINGPONG] & rx_next_bank;
						rx_cnt <= csr[CSR_RXCNT_LSB +: CSR_RXCNT_W];
						rx_len <= (csr[CSR_RXCNT_LSB +: CSR_RXCNT_W] > 11'h040) ? 7'h40 :
							csr[CSR_RXCNT_LSB +: BUF_AW+1];
						state <= (csr[CSR_RXCNT_LSB +: CSR_RXCNT_W] == 11'h000) ?
							S_CLR_RX : S_RX;
					end else if (csr[CSR_TX_COMPLETE] & tx_inflight) begin
						// Bank freed by the host's ACK; reload before clearing complete
						if (ctrl[CTRL_PINGPONG] & pp_held) begin
							clr_after <= 1'b1;
							state <= S_SET_RDY;
						end else if (~ctrl[CTRL_PINGPONG] & tx_pend) begin
							clr_after <= 1'b1;
							state <= (tx_len == 7'h00) ? S_SET_RDY : S_TX;
						end else begin
							state <= S_CLR_COMP;
						end
					end else if (tx_pend & ~pp_held &
						(ctrl[CTRL_PINGPONG] | ~csr[CSR_TX_PKT_READY] & ~tx_inflight)) begin
						// Second bank may be filled while the first is still owned
						clr_after <= 1'b0;
						state <= (tx_len == 7'h00) ? S_SET_RDY : S_TX;
					end else begin
						// Nothing released yet: device NAKs, so poll again later
						state <= S_IDLE;
					end
				end
			end
			S_SETUP: begin
				if (~dev_wait & (idx != 7'h08)) begin
					acc_req <= 1'b1;
					acc_we <= 1'b0;
					acc_sel <= DEV_SEL_FIFO;
				end
				if (acc_done) begin
					idx <= idx + 7'h01;
					if (idx == SETUP_LAST) begin
						state <= S_CLR_SETUP;
					end
				end
			end
			S_CLR_SETUP: begin
				if (~dev_wait & ~acc_done) begin
					acc_req <= 1'b1;
					acc_we <= 1'b1;
					acc_sel <= DEV_SEL_CSR;
					acc_wdata <= CSR_KEEP & ~(32'h0000_0001 << CSR_SETUP);
				end
				if (acc_done) begin
					state <= S_IDLE;
				end
			end
			S_RX: begin
				if (~dev_wait & (idx != rx_len)) begin
					acc_req <= 1'b1;
					acc_we <= 1'b0;
					acc_sel <= DEV_SEL_FIFO;
				end
				if (acc_done) begin
					idx <= idx + 7'h01;
					if (idx + 7'h01 == rx_len) begin
						state <= S_CLR_RX;
					end
				end
			end
			S_CLR_RX: begin
				// Flag released only after the last FIFO read has completed
				if (~dev_wait & ~acc_done) begin
					acc_req <= 1'b1;
					acc_we <= 1'b1;
					acc_sel <= DEV_SEL_CSR;
					acc_wdata <= CSR_KEEP & ~(32'h0000_0001 <<
						(rx_bank ? CSR_RX_BANK1 : CSR_RX_BANK0));
				end
				if (acc_done) begin
					rx_next_bank <= ctrl[CTRL_PINGPONG] & ~rx_bank;
					state <= S_IDLE;
				end
			end
			S_TX: begin
				if (~dev_wait & (idx != tx_len)) begin
					acc_req <= 1'b1;
					acc_we <= 1'b1;
					acc_sel <= DEV_SEL_FIFO;
					acc_wdata <= {24'h00_0000, tx_buf[idx[BUF_AW-1:0]]};
				end
				if (acc_done) begin
					idx <= idx + 7'h01;
					if (idx + 7'h01 == tx_len) begin
						if (ctrl[CTRL_PINGPONG] & tx_inflight) begin
							// Hold this bank until the first one completes
							pp_held <= 1'b1;
							state <= S_IDLE;
						end else begin
							state <= S_SET_RDY;
						end
					end
				end
			end
			S_SET_RDY: begin
				if (~dev_wait & ~acc_done) begin
					acc_req <= 1'b1;
					acc_we <= 1'b1;
					acc_sel <= DEV_SEL_CSR;
					acc_wdata <= CSR_KEEP | CSR_SET_TX_READY;
				end
				if (acc_done) begin
					tx_inflight <= 1'b1;
					pp_held <= 1'b0;
					state <= clr_after ? S_CLR_COMP : S_IDLE;
				end
			end
			S_CLR_COMP: begin
				if (~dev_wait & ~acc_done) begin
					acc_req <= 1'b1;
					acc_we <= 1'b1;
					acc_sel <= DEV_SEL_CSR;
					acc_wdata <= CSR_KEEP & ~(32'h0000_0001 << CSR_TX_COMPLETE);
				end
				if (acc_done) begin
					tx_inflight <= clr_after;
					clr_after <= 1'b0;
					state <= S_IDLE;
				end
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

	// Captured payloads, stored by byte index as each read returns
	always_ff @(posedge i_core_clk) begin
		if (acc_done & (state == S_SETUP)) begin
			setup_buf[idx[2:0]] <= acc_rdata[7:0];
		end
		if (acc_done & (state == S_RX)) begin
			rx_buf[idx[BUF_AW-1:0]] <= acc_rdata[7:0];
		end
	end

	// Hardware sets win over a software clear in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			rx_valid <= 1'b0;
			setup_valid <= 1'b0;
			tx_done <= 1'b0;
		end else begin
			if (state == S_CLR_RX & acc_done) begin
				rx_valid <= 1'b1;
			end else if (wr_status & i_wb_dat[ST_RX_VALID]) begin
				rx_valid <= 1'b0;
			end
			if (state == S_CLR_SETUP & acc_done) begin
				setup_valid <= 1'b1;
			end else if (wr_status & i_wb_dat[ST_SETUP_VALID]) begin
				setup_valid <= 1'b0;
			end
			if (state == S_CLR_COMP & acc_done) begin
				tx_done <= 1'b1;
			end else if (wr_status & i_wb_dat[ST_TX_DONE]) begin
				tx_done <= 1'b0;
			end
		end
	end
endmodule : ueth_host

// file: ueth_host_asserts.sv
`timescale 1ns/10ps
module ueth_host_chk import ueth_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic o_dev_sel,
	input wire logic o_dev_wr,
	input wire logic o_dev_rd,
	input wire logic [31:0] o_dev_wdata,
	input wire logic [31:0] i_dev_rdata,
	input wire logic i_dev_irq
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	logic [7:0] fifo_rds;
	logic rx_freed;
	// Saturates so a long receive cannot wrap back under the setup length
	always_ff @(posedge i_core_clk) begin
		if (i_srst || (o_dev_rd && o_dev_sel == DEV_SEL_CSR)) fifo_rds <= '0;
		else if (o_dev_rd && o_dev_sel == DEV_SEL_FIFO && fifo_rds != 8'hff) fifo_rds <= fifo_rds + 1;
	end
	always_ff @(posedge i_core_clk) begin
		if (i_srst || (o_dev_rd && o_dev_sel == DEV_SEL_CSR)) rx_freed <= 1'b0;
		else if (o_dev_wr && o_dev_sel == DEV_SEL_CSR && !(o_dev_wdata[1] && o_dev_wdata[6])) rx_freed <= 1'b1;
	end
	sequence wb_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence dev_acc;
		o_dev_rd || o_dev_wr;
	endsequence
	ack_timing_a: assert property (wb_req |=> o_wb_ack) else $error("ack late");
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack unasked");
	access_gap_a: assert property (dev_acc |=> (!o_dev_rd && !o_dev_wr)[*2]) else $error("gap");
	strobe_excl_a: assert property (!(o_dev_rd && o_dev_wr)) else $error("rd and wr");
	setup_read_a: assert property (
		o_dev_wr && o_dev_sel == DEV_SEL_CSR && !o_dev_wdata[CSR_SETUP]
		|-> fifo_rds >= 8'(SETUP_LEN)) else $error("setup cleared early");
	rx_release_a: assert property (dev_acc and o_dev_sel == DEV_SEL_FIFO |-> !rx_freed)
		else $error("fifo touched after release");
	unmapped_zero_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr > REG_SETUP_HI
		|-> o_wb_dat == 32'h0000_0000) else $error("unmapped read not zero");
	reset_idle_a: assert property ($fell(i_srst) |-> !o_wb_ack && !o_dev_rd && !o_dev_wr)
		else $error("busy after reset");
endmodule : ueth_host_chk

// file: ueth_dev_model.sv
`timescale 1ns/10ps
module ueth_dev_model import ueth_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_dev_sel,
	input wire logic i_dev_wr,
	input wire logic i_dev_rd,
	input wire logic [31:0] i_dev_wdata,
	output logic [31:0] o_dev_rdata,
	output logic o_dev_irq
);
	logic [7:0] mem [BUF_DEPTH];
	logic [7:0] txm [BUF_DEPTH];
	logic txc, rx0, setup, txrdy;
	logic [31:0] last, word;
	int rxn = 0, rptr, wptr, sent_len = 0, ack_dly = 1, wait_cnt;
	assign word = {5'h00, 11'(rxn), 11'h000, txrdy, 1'b0, setup, rx0, txc};
	// Idle data lines show the inverse of the last value, never a stale match
	assign o_dev_rdata = !i_dev_rd ? ~last : i_dev_sel ? {24'h00_0000, mem[rptr]} : word;
	assign o_dev_irq = txc | rx0 | setup;
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			{txc, rx0, setup, txrdy} <= 4'h0;
			last <= '0;
			wptr <= 0;
		end else begin
			if (i_dev_rd) last <= o_dev_rdata;
			if (i_dev_rd && i_dev_sel) rptr <= rptr + 1;
			if (i_dev_wr && i_dev_sel) begin
				txm[wptr] <= i_dev_wdata[7:0];
				wptr <= wptr + 1;
			end
			if (i_dev_wr && !i_dev_sel) begin
				if (!i_dev_wdata[CSR_TX_COMPLETE]) txc <= 1'b0;
				if (!i_dev_wdata[CSR_RX_BANK0]) rx0 <= 1'b0;
				if (!i_dev_wdata[CSR_SETUP]) setup <= 1'b0;
				if (i_dev_wdata[CSR_TX_PKT_READY] && !txrdy) begin
					txrdy <= 1'b1;
					sent_len <= wptr;
					wptr <= 0;
					wait_cnt <= ack_dly;
				end
			end
			// IN tokens get NAK until a packet is released, then host ACK
			if (txrdy && wait_cnt > 0) wait_cnt <= wait_cnt - 1;
			else if (txrdy) {txrdy, txc} <= 2'b01;
		end
	end
	task put_setup(input logic [63:0] b);
		while (rx0 || setup) @(posedge i_core_clk);
		@(posedge i_core_clk);
		for (int i = 0; i < SETUP_LEN; i++) mem[i] = b[8*i +: 8];
		rxn = SETUP_LEN;
		rptr <= 0;
		setup <= 1'b1;
	endtask : put_setup
	task put_out(input int n, input logic [7:0] d [BUF_DEPTH]);
		while (rx0 || setup) @(posedge i_core_clk);
		@(posedge i_core_clk);
		for (int i = 0; i < BUF_DEPTH; i++) mem[i] = d[i];
		rxn = n;
		rptr <= 0;
		rx0 <= 1'b1;
	endtask : put_out
endmodule : ueth_dev_model

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import ueth_pkg::*;
	logic i_core_clk = 0, i_srst = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
	logic [7:0] i_wb_adr = '0;
	logic [3:0] i_wb_sel = '0;
	logic [31:0] i_wb_dat = '0, rd_last, o_wb_dat, o_dev_wdata, i_dev_rdata;
	logic o_wb_ack, o_dev_sel, o_dev_wr, o_dev_rd, i_dev_irq;
	logic [32:0] exp_q [$];
	logic [32:0] note;
	logic [7:0] pay [BUF_DEPTH];
	logic [63:0] sb;
	int err_count = 0, cmp_count = 0, cycles = 0, n;
	always #5 i_core_clk = ~i_core_clk;
	ueth_host dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc),
		.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
		.i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_dev_sel(o_dev_sel),
		.o_dev_wr(o_dev_wr), .o_dev_rd(o_dev_rd), .o_dev_wdata(o_dev_wdata),
		.i_dev_rdata(i_dev_rdata), .i_dev_irq(i_dev_irq));
	ueth_dev_model dev (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_dev_sel(o_dev_sel),
		.i_dev_wr(o_dev_wr), .i_dev_rd(o_dev_rd), .i_dev_wdata(o_dev_wdata),
		.o_dev_rdata(i_dev_rdata), .o_dev_irq(i_dev_irq));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task complete_run;
		$display("mismatches %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		int k;
		k = 0;
		if (!w) exp_q.push_back({c, d});
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_sel <= 4'hf;
		i_wb_dat <= w ? d : $urandom;
		do begin
			@(posedge i_core_clk);
			k++;
		end while (!o_wb_ack && k < 50);
		if (!o_wb_ack) err_count++;
		rd_last = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		@(posedge i_core_clk);
	endtask : wb
	task poll(input int b);
		int k;
		k = 0;
		do begin
			wb(0, REG_STATUS, 0, 0);
			k++;
		end while (rd_last[b] !== 1'b1 && k < 300);
		chk(rd_last[b], 1);
	endtask : poll
	// Read results are judged where they appear, against the oldest note
	always @(posedge i_core_clk) begin
		if (o_wb_ack && i_wb_cyc && !i_wb_we && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			if (note[32]) chk(o_wb_dat, note[31:0]);
		end
	end
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_count++;
			complete_run;
		end
	end
	initial begin
		void'($urandom(13));
		repeat (12) @(posedge i_core_clk);
		i_srst <= 1'b0;
		@(posedge i_core_clk);
		wb(0, REG_CTRL, 0, 1);
		wb(0, REG_STATUS, 0, 1);
		wb(1, 8'h24, 32'hffff_ffff, 0);
		wb(0, 8'h24, 0, 1);
		wb(1, REG_CTRL, 32'h1, 0);
		sb = {$urandom, $urandom};
		dev.put_setup(sb);
		poll(ST_SETUP_VALID);
		chk(dev.setup, 0);
		wb(0, REG_SETUP_LO, sb[31:0], 1);
		wb(0, REG_SETUP_HI, sb[63:32], 1);
		wb(1, REG_STATUS, 32'h8, 0);
		// First packet is the empty status OUT stage
		for (int k = 0; k < 4; k++) begin
			n = k == 0 ? 0 : k == 1 ? 1 : k == 2 ? BUF_DEPTH : 2 + $urandom_range(61);
			foreach (pay[i]) pay[i] = 8'($urandom);
			dev.put_out(n, pay);
			poll(ST_RX_VALID);
			chk(dev.rx0, 0);
			wb(0, REG_RXCOUNT, n, 1);
			for (int i = 0; i < n; i++) wb(0, REG_RXDATA, {24'h00_0000, pay[i]}, 1);
			wb(1, REG_STATUS, 32'h4, 0);
		end
		// A staged packet, then the empty status IN packet behind a slow host ACK
		for (int k = 0; k < 2; k++) begin
			dev.ack_dly = k ? 40 : 1;
			n = k ? 0 : 3;
			for (int i = 0; i < n; i++) wb(1, REG_TXDATA, {24'h00_0000, pay[i]}, 0);
			wb(1, REG_CMD, 32'h1, 0);
			poll(ST_TX_DONE);
			chk(dev.sent_len, n);
			for (int i = 0; i < n; i++) chk(dev.txm[i], pay[i]);
			chk(dev.txc, 0);
			wb(1, REG_STATUS, 32'h2, 0);
		end
		wb(1, REG_CTRL, 32'h5, 0);
		wb(1, REG_CMD, 32'h1, 0);
		wb(0, REG_STATUS, 0, 0);
		chk(rd_last[ST_TX_PEND], 0);
		wb(1, REG_CTRL, 32'h3, 0);
		dev.put_setup(sb);
		poll(ST_ERR);
		i_srst <= 1'b1;
		repeat (12) @(posedge i_core_clk);
		i_srst <= 1'b0;
		@(posedge i_core_clk);
		wb(0, REG_CTRL, 0, 1);
		complete_run;
	end
endmodule : tb_top
bind ueth_host ueth_host_chk chk_i (.i_core_clk(i_core_clk), .i_srst(i_srst),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_dev_sel(o_dev_sel), .o_dev_wr(o_dev_wr), .o_dev_rd(o_dev_rd),
	.o_dev_wdata(o_dev_wdata), .i_dev_rdata(i_dev_rdata), .i_dev_irq(i_dev_irq));
